/* File: psmp_pkg.sv */
// Purpose: shared constants for the packed saturating multiply and pack datapath
// Assumes: 32-bit register words, 16-bit packed halves
// Notes:   pipeline depth of the multiply counts the stages between the first execute stage and the write stage
package psmp_pkg;
	localparam int unsigned WORD_W      = 32;
	localparam int unsigned HALF_W      = 16;
	localparam int unsigned REG_ADDR_W  = 5;
	localparam int unsigned MUL_STAGES  = 3;
	localparam logic [31:0] MUL_NEG_MAX = 32'h80000000;
	localparam logic [31:0] MUL_POS_MAX = 32'h7fffffff;
	localparam logic [15:0] HALF_POS    = 16'h7fff;
	localparam logic [15:0] HALF_NEG    = 16'h8000;
	localparam logic [31:0] PACK_HI_LIM = 32'h00007fff;
	localparam logic [31:0] PACK_LO_LIM = 32'hffff8000;
	localparam logic        FLAG_RESET  = 1'b0;
	localparam logic [4:0]  EVEN_ADDR_RESET = 5'h00;
	localparam logic [4:0]  ODD_ADDR_RESET  = 5'h01;
	localparam logic [4:0]  PACK_ADDR_RESET = 5'h00;
	localparam logic [63:0] MUL_DATA_RESET  = 64'h0000000000000000;
	localparam logic [31:0] PACK_DATA_RESET = 32'h00000000;
endpackage : psmp_pkg

/* File: psmp_datapath.sv */
// Purpose: dual signed multiply with doubling and clamp, and dual clamp-and-pack
// Assumes: pipeline control issues at most one operation per cycle per operation kind
// Notes:   the flag output is the overflow clamp bit of the control status word
//
// How it works
// RULE_01: the multiply splits each operand into two signed halves and multiplies low by low and high by high.
// RULE_02: each product is doubled, and a doubled value of 0x80000000 becomes 0x7fffffff.
// RULE_03: the multiply delivers both 32-bit results together as one 64-bit result to a register pair.
// RULE_04: the clamped low product goes to the even register and the clamped high product to the odd one.
// RULE_05: if either product clamps, the flag is set in the same cycle the result is written.
// RULE_06: if neither product clamps, the flag keeps its previous value.
// RULE_07: the pack clamps each signed 32-bit operand to signed 16 bits independently.
// RULE_08: the clamped first operand goes to the upper half and the clamped second to the lower half.
// RULE_09: a value inside the 16-bit range passes as its low 16 bits.
// RULE_10: a value above 0x7fff yields 0x7fff.
// RULE_11: a value below -0x8000 yields 0x8000.
// RULE_12: the pack never touches the flag.
// RULE_13: the multiply reads in the first execute stage and writes in the fifth; the pack takes one cycle.
// RULE_14: a false predicate makes either operation a no-operation.
module psmp_datapath
(
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic        mulIssue,
	input  wire logic        mulPredOk,
	input  wire logic [31:0] mulFirstOperand,
	input  wire logic [31:0] mulSecondOperand,
	input  wire logic [3:0]  mulDstPair,
	input  wire logic        packIssue,
	input  wire logic        packPredOk,
	input  wire logic [31:0] packFirstOperand,
	input  wire logic [31:0] packSecondOperand,
	input  wire logic [4:0]  packDst,
	output logic             mulWrEn,
	output logic [4:0]       mulWrEvenAddr,
	output logic [4:0]       mulWrOddAddr,
	output logic [63:0]      mulWrData,
	output logic             packWrEn,
	output logic [4:0]       packWrAddr,
	output logic [31:0]      packWrData,
	output logic             overflowClampFlag
);

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic [32:0] dual_mul_shift_clamp(input logic [15:0] a, input logic [15:0] b);
		logic signed [31:0] prod;
		logic        [31:0] dbl;
		prod = $signed(a) * $signed(b); // RULE_01
		dbl  = {prod[30:0], 1'b0}; // RULE_02
		if (dbl == psmp_pkg::MUL_NEG_MAX)
			dual_mul_shift_clamp = {1'b1, psmp_pkg::MUL_POS_MAX}; // RULE_02
		else
			dual_mul_shift_clamp = {1'b0, dbl};
	endfunction : dual_mul_shift_clamp

	function automatic logic [15:0] clamp_half(input logic [31:0] v);
		if ($signed(v) > $signed(psmp_pkg::PACK_HI_LIM))
			clamp_half = psmp_pkg::HALF_POS; // RULE_10
		else if ($signed(v) < $signed(psmp_pkg::PACK_LO_LIM))
			clamp_half = psmp_pkg::HALF_NEG; // RULE_11
		else
			clamp_half = v[15:0]; // RULE_09
	endfunction : clamp_half

	// ************************************************************
	// multiply pipeline
	// ************************************************************
	localparam int unsigned NS = psmp_pkg::MUL_STAGES;

	logic [NS-1:0] vldReg,  vldNext;
	logic [3:0]    pairReg [NS],  pairNext [NS];
	logic [31:0]   loReg   [NS],  loNext   [NS];
	logic [31:0]   hiReg   [NS],  hiNext   [NS];
	logic [NS-1:0] satReg,  satNext;
	logic [32:0]   loRes;
	logic [32:0]   hiRes;

	always_comb
	begin
		loRes = dual_mul_shift_clamp(mulFirstOperand[15:0], mulSecondOperand[15:0]); // RULE_01
		hiRes = dual_mul_shift_clamp(mulFirstOperand[31:16], mulSecondOperand[31:16]); // RULE_01
		vldNext[0]  = mulIssue && mulPredOk; // RULE_14
		pairNext[0] = mulDstPair;
		loNext[0]   = loRes[31:0];
		hiNext[0]   = hiRes[31:0];
		satNext[0]  = loRes[32] | hiRes[32];
		for (int i = 1; i < NS; i++)
		begin
			vldNext[i]  = vldReg[i-1]; // RULE_13
			pairNext[i] = pairReg[i-1];
			loNext[i]   = loReg[i-1];
			hiNext[i]   = hiReg[i-1];
			satNext[i]  = satReg[i-1];
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			vldReg <= '0;
			satReg <= '0;
			for (int i = 0; i < NS; i++)
			begin
				pairReg[i] <= 4'h0;
				loReg[i]   <= 32'h00000000;
				hiReg[i]   <= 32'h00000000;
			end
		end
		else
		begin
			vldReg <= vldNext;
			satReg <= satNext;
			for (int i = 0; i < NS; i++)
			begin
				pairReg[i] <= pairNext[i];
				loReg[i]   <= loNext[i];
				hiReg[i]   <= hiNext[i];
			end
		end
	end

	// ************************************************************
	// multiply write-back
	// ************************************************************
	logic        mulWrEnReg,    mulWrEnNext;
	logic [4:0]  mulEvenReg,    mulEvenNext;
	logic [4:0]  mulOddReg,     mulOddNext;
	logic [63:0] mulDataReg,    mulDataNext;

	always_comb
	begin
		mulWrEnNext = vldReg[NS-1]; // RULE_13
		mulEvenNext = {pairReg[NS-1], 1'b0}; // RULE_04
		mulOddNext  = {pairReg[NS-1], 1'b1}; // RULE_04
		mulDataNext = {hiReg[NS-1], loReg[NS-1]}; // RULE_03
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			mulWrEnReg <= 1'b0;
			mulEvenReg <= psmp_pkg::EVEN_ADDR_RESET;
			mulOddReg  <= psmp_pkg::ODD_ADDR_RESET;
			mulDataReg <= psmp_pkg::MUL_DATA_RESET;
		end
		else
		begin
			mulWrEnReg <= mulWrEnNext;
			mulEvenReg <= mulEvenNext;
			mulOddReg  <= mulOddNext;
			mulDataReg <= mulDataNext;
		end
	end

	// ************************************************************
	// pack
	// ************************************************************
	logic        packWrEnReg,   packWrEnNext;
	logic [4:0]  packAddrReg,   packAddrNext;
	logic [31:0] packDataReg,   packDataNext;

	always_comb
	begin
		packWrEnNext = packIssue && packPredOk; // RULE_14
		packAddrNext = packDst;
		packDataNext = {clamp_half(packFirstOperand), clamp_half(packSecondOperand)}; // RULE_08
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			packWrEnReg <= 1'b0;
			packAddrReg <= psmp_pkg::PACK_ADDR_RESET;
			packDataReg <= psmp_pkg::PACK_DATA_RESET;
		end
		else
		begin
			packWrEnReg <= packWrEnNext;
			packAddrReg <= packAddrNext;
			packDataReg <= packDataNext; // RULE_07
		end
	end

	// ************************************************************
	// overflow clamp flag
	// ************************************************************
	logic        flagReg,       flagNext;

	always_comb
	begin
		// flag updates with the write; pack has no path to it
		flagNext = flagReg; // RULE_06
		if (vldReg[NS-1] && satReg[NS-1])
			flagNext = 1'b1; // RULE_05
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			flagReg <= psmp_pkg::FLAG_RESET;
		else
			flagReg <= flagNext; // RULE_12
	end

	assign mulWrEn           = mulWrEnReg;
	assign mulWrEvenAddr     = mulEvenReg;
	assign mulWrOddAddr      = mulOddReg;
	assign mulWrData         = mulDataReg;
	assign packWrEn          = packWrEnReg;
	assign packWrAddr        = packAddrReg;
	assign packWrData        = packDataReg;
	assign overflowClampFlag = flagReg;

endmodule : psmp_datapath

/* File: psmp_datapath_sva.sv */
// Purpose: port checks of the multiply and pack datapath
// Assumes: one clock domain, synchronous reset
// Notes:   pack data is judged against a local clamp
// ****
// checker
// ****
module psmp_datapath_sva
(
	input wire logic        core_clk,
	input wire logic        sys_rst,
	input wire logic        mulIssue,
	input wire logic        mulPredOk,
	input wire logic        packIssue,
	input wire logic        packPredOk,
	input wire logic [31:0] packFirstOperand,
	input wire logic [31:0] packSecondOperand,
	input wire logic        mulWrEn,
	input wire logic [4:0]  mulWrEvenAddr,
	input wire logic [4:0]  mulWrOddAddr,
	input wire logic [63:0] mulWrData,
	input wire logic        packWrEn,
	input wire logic [31:0] packWrData,
	input wire logic        overflowClampFlag
);
	function automatic logic [15:0] clampHalf(input logic [31:0] v);
		return ($signed(v) > 32767) ? 16'h7fff : (($signed(v) < -32768) ? 16'h8000 : v[15:0]);
	endfunction : clampHalf
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	AST_MUL_LAT: assert property (mulIssue && mulPredOk |-> ##4 mulWrEn)
		else $error("multiply write-back not four cycles after issue");
	AST_MUL_NOP: assert property (!(mulIssue && mulPredOk) |-> ##4 !mulWrEn)
		else $error("multiply write-back without a taken issue");
	AST_PACK_LAT: assert property (packIssue && packPredOk |=> packWrEn)
		else $error("pack write missing one cycle after issue");
	AST_PACK_NOP: assert property (!(packIssue && packPredOk) |=> !packWrEn)
		else $error("pack write without a taken issue");
	AST_PACK_DATA: assert property (packIssue && packPredOk |=> packWrData ==
		{clampHalf($past(packFirstOperand)), clampHalf($past(packSecondOperand))})
		else $error("pack data wrong");
	AST_MUL_PAIR: assert property (mulWrEn |-> !mulWrEvenAddr[0] && mulWrOddAddr == (mulWrEvenAddr | 5'h01))
		else $error("multiply pair addresses wrong");
	AST_FLAG_SET: assert property (mulWrEn && (mulWrData[31:0] == psmp_pkg::MUL_POS_MAX ||
		mulWrData[63:32] == psmp_pkg::MUL_POS_MAX) |-> overflowClampFlag)
		else $error("clamp flag not set with clamped product");
	AST_FLAG_HOLD: assert property (overflowClampFlag |=> overflowClampFlag)
		else $error("clamp flag cleared");
	AST_FLAG_CAUSE: assert property ($rose(overflowClampFlag) |-> mulWrEn)
		else $error("clamp flag set without a multiply write-back");
endmodule : psmp_datapath_sva
bind psmp_datapath psmp_datapath_sva chk (.*);

/* File: psmp_regfile_model.sv */
// Purpose: register file that collects write-backs
// Assumes: writes land on the rising edge
// Notes:   preset contents reveal writes that should not happen
module psmp_regfile_model
(
	input wire logic        core_clk,
	input wire logic        mulWrEn,
	input wire logic [4:0]  mulWrEvenAddr,
	input wire logic [4:0]  mulWrOddAddr,
	input wire logic [63:0] mulWrData,
	input wire logic        packWrEn,
	input wire logic [4:0]  packWrAddr,
	input wire logic [31:0] packWrData
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] regs [32];
	initial for (int i = 0; i < 32; i++) regs[i] = 32'h5a5a0000 + i;
	always @(posedge core_clk)
	begin
		if (mulWrEn)
			{regs[mulWrOddAddr], regs[mulWrEvenAddr]} <= mulWrData;
		if (packWrEn)
			regs[packWrAddr] <= packWrData;
	end
endmodule : psmp_regfile_model

/* File: psmp_datapath_tb_top.sv */
// Purpose: self-checking bench of the multiply and pack datapath
// Assumes: inputs change at the falling edge
// Notes:   results are read back from the register file model
module psmp_datapath_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk = 1'b0, sys_rst = 1'b1, mulIssue = 1'b0, mulPredOk = 1'b0;
	logic        packIssue = 1'b0, packPredOk = 1'b0, mulWrEn, packWrEn, overflowClampFlag;
	logic [31:0] mulFirstOperand = 32'h0, mulSecondOperand = 32'h0, packWrData;
	logic [31:0] packFirstOperand = 32'h0, packSecondOperand = 32'h0;
	logic [3:0]  mulDstPair = 4'h0;
	logic [4:0]  packDst = 5'h00, mulWrEvenAddr, mulWrOddAddr, packWrAddr;
	logic [63:0] mulWrData;
	int          failures = 0, n_tests = 0, cycles = 0;
	psmp_datapath dut (.*);
	psmp_regfile_model rf (.*);
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) if (++cycles == 3000) begin failures++; summarize(); end
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH %s exp %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic drive(input logic isMul, ok, input logic [31:0] a, b, input logic [4:0] d);
		@(negedge core_clk);
		{mulIssue, packIssue, mulPredOk, packPredOk} = {isMul, !isMul, ok, ok};
		{mulFirstOperand, mulSecondOperand, packFirstOperand, packSecondOperand} = {a, b, a, b};
		{mulDstPair, packDst} = {d[4:1], d};
	endtask : drive
	task automatic idle;
		@(negedge core_clk);
		{mulIssue, packIssue} = 2'h0;
		repeat (5) @(negedge core_clk);
	endtask : idle
	task automatic testMul;
		drive(1'b1, 1'b1, 32'h6a321193, 32'hb1746ca4, 5'h08);
		idle();
		check("even", rf.regs[8], 32'h0eea8c58);
		check("odd", rf.regs[9], 32'hbed56150);
	endtask : testMul
	task automatic testPack;
		logic [31:0] ta [6] = '{32'h3789f23a, 32'ha1242451, 32'h00007fff, 32'h00008000, 32'h1234, 32'h1};
		logic [31:0] tb [6] = '{32'h04b84975, 32'h01a6a051, 32'hffff8000, 32'hffff7fff, 32'hfedc, 32'h2};
		logic [31:0] te [5] = '{32'h7fff7fff, 32'h80007fff, 32'h7fff8000, 32'h7fff8000, 32'h12347fff};
		for (int i = 0; i < 6; i++) drive(1'b0, i < 5, ta[i], tb[i], 5'h10 + 5'(i));
		idle();
		for (int i = 0; i < 5; i++) check("pack", rf.regs[16 + i], te[i]);
		check("pack nop", rf.regs[21], 32'h5a5a0015);
		check("flag pack", overflowClampFlag, 1'b0);
	endtask : testPack
	task automatic testSat;
		drive(1'b1, 1'b0, 32'h80008000, 32'h80008000, 5'h02);
		idle();
		check("nop reg", rf.regs[2], 32'h5a5a0002);
		check("flag nop", overflowClampFlag, 1'b0);
		drive(1'b1, 1'b1, 32'h00018000, 32'h00018000, 5'h02);
		idle();
		check("sat even", rf.regs[2], 32'h7fffffff);
		check("sat odd", rf.regs[3], 32'h00000002);
		check("flag set", overflowClampFlag, 1'b1);
		drive(1'b1, 1'b1, 32'h00020003, 32'h00020003, 5'h04);
		idle();
		check("plain", rf.regs[4], 32'h00000012);
		check("flag kept", overflowClampFlag, 1'b1);
	endtask : testSat
	task automatic summarize;
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize
	initial
	begin
		repeat (10) @(negedge core_clk);
		sys_rst = 1'b0;
		testMul();
		testPack();
		testSat();
		summarize();
	end
endmodule : psmp_datapath_tb_top
